// ===== rtl/i2cpr_pkg.sv
// constants and types for the paged register port on the two-wire bus
package i2cpr_pkg;
    localparam int          ADDR_W       = 16;       // register address width
    localparam int          DATA_W       = 8;        // bytes on the bus
    localparam int          PAGE_W       = 32;       // page register width
    localparam int          USER_BIT     = 15;       // set for user registers
    localparam int          PAGE_HI_LSB  = 8;        // page byte used in 1-byte mode
    localparam logic [6:0]  DEF_DEV_ADDR = 7'h58;    // 1011000b
    localparam logic [7:0]  PAGE_OFS_1B  = 8'hFC;    // page reg offset, 1-byte mode
    localparam logic [15:0] PAGE_OFS_2B  = 16'hFFFC; // page reg offset, 2-byte mode
    localparam logic [31:0] PAGE_RST     = 32'h0000_0000;
    localparam logic [3:0]  LAST_BIT     = 4'h7;     // eighth bit of a byte
    localparam logic [3:0]  BYTE_DONE    = 4'h8;     // all bits of a read byte sent
    localparam int          SCL_MAX_HZ   = 1000000;  // fastest supported bus rate
    localparam int          LINK_MIN_HZ  = 16 * SCL_MAX_HZ; // oversampling floor

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_AACK, ST_OFFS, ST_OACK,
        ST_WDAT, ST_WACK, ST_RDAT, ST_RACK
    } i2cpr_state_t;
endpackage

// ===== rtl/i2cpr_slave_port.sv
// two-wire bus slave port reaching the 16-bit register space with paging
//
// Notes on behaviour
// [R1] every access resolves to a 16-bit address
// [R2] only the upper half holds user registers
// [R3] seven-bit base bus address held internally
// [R4] default base address is 1011000b
// [R5] two strap pins set address bits 0,1
// [R6] optional gpio level at reset sets bit 2
// [R7] host keeps strap pins static in bus mode
// [R8] offset field is one or two bytes
// [R9] all offset bits are register address bits
// [R10] one-byte mode: page byte plus offset byte
// [R11] page register at 0xFC, one burst write
// [R12] two-byte mode: full address, page at 0xFFFC
// [R13] pointer advances after every data byte
// [R14] host moves multi-byte registers in one burst
// [R15] host keeps one-byte bursts inside the page
// [R16] runs at 100k, 400k and 1M bus rates
// [R17] serves accesses only after reset sequence done
// [R18] host writes port settings in one burst
// [R19] reads: offset write, repeated start, read
// [R20] acknowledge only the own bus address
`timescale 1ns/1ps
module i2cpr_slave_port (
    input  wire logic        sys_clk_in,            // core clock
    input  wire logic        rst_in,                // synchronous reset, high
    input  wire logic        ce_in,                 // clock enable, freezes state
    input  wire logic        link_clk_in,           // bus oversampling clock
    input  wire logic        scl_in,                // bus clock pin level
    output logic             scl_out,               // bus clock drive value (0)
    output logic             scl_oe_n_out,          // low while stretching
    input  wire logic        sda_in,                // bus data pin level
    output logic             sda_out,               // bus data drive value (0)
    output logic             sda_oe_n_out,          // low while pulling data
    input  wire logic        addr_strap_bit0_in,    // address bit 0 pin
    input  wire logic        addr_strap_bit1_in,    // address bit 1 pin
    input  wire logic        addr_strap_bit2_in,    // gpio caught at reset
    input  wire logic        strap_bit2_en_in,      // use gpio for bit 2
    input  wire logic [6:0]  base_addr_in,          // stored base address
    input  wire logic        base_addr_valid_in,    // stored address present
    input  wire logic        two_byte_offset_mode_in, // 1: two_byte_offset_mode
    input  wire logic        reset_done_in,         // reset sequence complete
    output logic [15:0]      core_addr_out,         // register address
    output logic [7:0]       core_wdata_out,        // write byte
    output logic             core_wr_out,           // write pulse
    output logic             core_rd_out,           // read pulse
    input  wire logic [7:0]  core_rdata_in,         // read byte, cycle after pulse
    output logic [6:0]       dev_addr_out           // resolved bus address
);
    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic        st0_s1, st0_s2, st1_s1, st1_s2, g2_s1, g2_s2;
    logic        rqs1, rqs2, rqs3;
    logic [31:0] pg_q, pg_d;
    logic [6:0]  dev_q, dev_d;
    logic        a2_q, a2_d, caught_q, caught_d;
    logic [15:0] caddr_q, caddr_d;
    logic [7:0]  cwd_q, cwd_d, rdata_q, rdata_d;
    logic        cwr_q, cwr_d, crd_q, crd_d, pend_q, pend_d, pend2_q, pend2_d;
    logic [1:0]  sel_q, sel_d, bsel_q, bsel_d;
    logic        ack_tog_q, ack_tog_d;
    logic [15:0] full_a;
    logic        pg_hit, req_ev;
    // link side
    logic        rl1, rl2, cl1, cl2, scl_s1, scl_s2, sda_s1, sda_s2, scl_p, sda_p;
    logic        ak1, ak2, ak3, two_l1, two_l2, rdy_l1, rdy_l2;
    logic [6:0]  dev_l1, dev_l2;
    i2cpr_pkg::i2cpr_state_t st_q, st_d;
    logic [3:0]  bit_q, bit_d;
    logic [7:0]  sh_q, sh_d, rdat_l, req_dat_q, req_dat_d;
    logic [1:0]  ob_q, ob_d;
    logic [15:0] ptr_q, ptr_d, req_addr_q, req_addr_d;
    logic        rw_q, rw_d, drv_q, drv_d, str_q, str_d, wait_q, wait_d, ph_q, ph_d;
    logic        req_tog_q, req_tog_d, req_wr_q, req_wr_d;
    logic        rise, fall, start, stop, ack_ev, wait_n, fev, issue, iss_wr;
    logic [7:0]  byte_in;

    ////////////////////////////////////////////////////////////////////////
    // core clock: pin and request synchronisers, no reset needed
    always_ff @(posedge sys_clk_in) begin
        st0_s1 <= addr_strap_bit0_in;
        st0_s2 <= st0_s1;
        st1_s1 <= addr_strap_bit1_in;
        st1_s2 <= st1_s1;
        g2_s1  <= addr_strap_bit2_in;
        g2_s2  <= g2_s1;
        rqs1   <= req_tog_q;
        rqs2   <= rqs1;
        rqs3   <= rqs2;
    end

    // address formation; request fields are held stable by the link side
    always_comb begin
        req_ev = rqs2 ^ rqs3;
        if (two_byte_offset_mode_in) begin
            full_a = req_addr_q;                                         // R12
            pg_hit = req_addr_q[15:2] == i2cpr_pkg::PAGE_OFS_2B[15:2];   // R12
        end else begin
            full_a = {pg_q[i2cpr_pkg::PAGE_HI_LSB +: 8], req_addr_q[7:0]}; // R10
            pg_hit = req_addr_q[7:2] == i2cpr_pkg::PAGE_OFS_1B[7:2];     // R11
        end
    end

    // core clock next state: address resolve, page register, access pacing
    always_comb begin
        pg_d      = pg_q;
        caught_d  = 1'b1;
        a2_d      = caught_q ? a2_q : g2_s2;                             // R6
        dev_d     = base_addr_valid_in ? base_addr_in                    // R3
                                       : i2cpr_pkg::DEF_DEV_ADDR;        // R4
        dev_d[2]  = strap_bit2_en_in ? a2_q : dev_d[2];                  // R6
        dev_d[1]  = st1_s2;                                              // R5
        dev_d[0]  = st0_s2;                                              // R5
        caddr_d   = caddr_q;
        cwd_d     = cwd_q;
        cwr_d     = 1'b0;
        crd_d     = 1'b0;
        pend_d    = 1'b0;
        pend2_d   = pend_q;
        sel_d     = sel_q;
        bsel_d    = bsel_q;
        rdata_d   = rdata_q;
        ack_tog_d = ack_tog_q;
        if (req_ev) begin
            pend_d  = 1'b1;
            bsel_d  = req_addr_q[1:0];
            caddr_d = full_a;                                            // R1
            cwd_d   = req_dat_q;
            if (pg_hit) begin
                sel_d = 2'h1;
                if (req_wr_q)
                    pg_d[{req_addr_q[1:0], 3'h0} +: 8] = req_dat_q;      // R11
            end else if (full_a[i2cpr_pkg::USER_BIT]) begin
                sel_d = 2'h0;                                            // R2
                cwr_d = req_wr_q;
                crd_d = ~req_wr_q;
            end else begin
                sel_d = 2'h2;                                            // R2
            end
        end
        // core data is valid the cycle after the read pulse
        if (pend2_q) begin
            ack_tog_d = ~ack_tog_q;
            if (sel_q == 2'h1)
                rdata_d = pg_q[{bsel_q, 3'h0} +: 8];
            else if (sel_q == 2'h0)
                rdata_d = core_rdata_in;
            else
                rdata_d = 8'h00;
        end
    end

    // core clock registers
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            pg_q <= i2cpr_pkg::PAGE_RST;   dev_q <= i2cpr_pkg::DEF_DEV_ADDR;
            a2_q <= 1'b0;                  caught_q <= 1'b0;
            caddr_q <= 16'h0000;           cwd_q <= 8'h00;
            cwr_q <= 1'b0;                 crd_q <= 1'b0;
            pend_q <= 1'b0;                pend2_q <= 1'b0;
            sel_q <= 2'h0;                 bsel_q <= 2'h0;
            rdata_q <= 8'h00;              ack_tog_q <= 1'b0;
        end else if (ce_in) begin
            pg_q <= pg_d;                  dev_q <= dev_d;
            a2_q <= a2_d;                  caught_q <= caught_d;
            caddr_q <= caddr_d;            cwd_q <= cwd_d;
            cwr_q <= cwr_d;                crd_q <= crd_d;
            pend_q <= pend_d;              pend2_q <= pend2_d;
            sel_q <= sel_d;                bsel_q <= bsel_d;
            rdata_q <= rdata_d;            ack_tog_q <= ack_tog_d;
        end
    end

    assign core_addr_out  = caddr_q;
    assign core_wdata_out = cwd_q;
    assign core_wr_out    = cwr_q;
    assign core_rd_out    = crd_q;
    assign dev_addr_out   = dev_q;

    ////////////////////////////////////////////////////////////////////////
    // link clock synchronisers; configuration levels are quasi-static
    always_ff @(posedge link_clk_in) begin
        rl1 <= rst_in;          rl2 <= rl1;
        cl1 <= ce_in;           cl2 <= cl1;
        scl_s1 <= scl_in;       scl_s2 <= scl_s1;
        sda_s1 <= sda_in;       sda_s2 <= sda_s1;
        ak1 <= ack_tog_q;       ak2 <= ak1;       ak3 <= ak2;
        dev_l1 <= dev_q;        dev_l2 <= dev_l1;                        // R7
        two_l1 <= two_byte_offset_mode_in;        two_l2 <= two_l1;      // R18
        rdy_l1 <= reset_done_in;                  rdy_l2 <= rdy_l1;
        scl_p <= scl_s2;        sda_p <= sda_s2;
    end

    // bus events from the oversampled pins
    always_comb begin
        rise    = scl_s2 & ~scl_p;
        fall    = ~scl_s2 & scl_p;
        start   = scl_s2 & scl_p & sda_p & ~sda_s2;
        stop    = scl_s2 & scl_p & ~sda_p & sda_s2;
        ack_ev  = ak2 ^ ak3;
        wait_n  = wait_q & ~ack_ev;
        // a fall while an access is open is held back by stretching
        fev     = (fall | str_q) & ~wait_n;                              // R16
        byte_in = {sh_q[6:0], sda_s2};
        rdat_l  = rdata_q;  // held stable by the core side after its toggle
    end

    // bus protocol next state
    always_comb begin
        st_d = st_q;  bit_d = bit_q;  sh_d = sh_q;  ob_d = ob_q;  ptr_d = ptr_q;
        rw_d = rw_q;  drv_d = drv_q;  ph_d = ph_q;
        req_tog_d = req_tog_q;  req_wr_d = req_wr_q;
        req_addr_d = req_addr_q;  req_dat_d = req_dat_q;
        wait_d = wait_n;
        str_d  = (fall | str_q) & wait_n;
        issue  = 1'b0;
        iss_wr = 1'b0;
        if (start) begin
            st_d = i2cpr_pkg::ST_ADDR;  bit_d = 4'h0;  ob_d = 2'h0;
            drv_d = 1'b0;  ph_d = 1'b0;
        end else if (stop) begin
            st_d = i2cpr_pkg::ST_IDLE;  drv_d = 1'b0;
        end else begin
            case (st_q)
                i2cpr_pkg::ST_ADDR, i2cpr_pkg::ST_OFFS, i2cpr_pkg::ST_WDAT: begin
                    if (rise) begin
                        sh_d  = byte_in;
                        bit_d = bit_q + 4'h1;
                        if (bit_q == i2cpr_pkg::LAST_BIT) begin
                            bit_d = 4'h0;
                            ph_d  = 1'b0;
                            if (st_q == i2cpr_pkg::ST_ADDR) begin
                                if (sh_q[6:0] == dev_l2 && rdy_l2) begin // R20 R17
                                    st_d  = i2cpr_pkg::ST_AACK;
                                    rw_d  = sda_s2;
                                    issue = sda_s2;                      // R19
                                end else begin
                                    st_d = i2cpr_pkg::ST_IDLE;           // R20
                                end
                            end else if (st_q == i2cpr_pkg::ST_OFFS) begin
                                st_d = i2cpr_pkg::ST_OACK;
                                ob_d = ob_q + 2'h1;
                                if (two_l2 && ob_q == 2'h0)
                                    ptr_d[15:8] = byte_in;               // R9
                                else
                                    ptr_d = {two_l2 ? ptr_q[15:8] : 8'h00, byte_in};  // R8
                            end else begin
                                st_d   = i2cpr_pkg::ST_WACK;
                                issue  = 1'b1;
                                iss_wr = 1'b1;
                            end
                        end
                    end
                end
                i2cpr_pkg::ST_AACK, i2cpr_pkg::ST_OACK, i2cpr_pkg::ST_WACK: begin
                    if (fev) begin
                        drv_d = ~ph_q;
                        ph_d  = ~ph_q;
                        if (ph_q) begin
                            if (st_q == i2cpr_pkg::ST_AACK && rw_q) begin
                                st_d  = i2cpr_pkg::ST_RDAT;
                                drv_d = ~rdat_l[7];
                                sh_d  = {rdat_l[6:0], 1'b0};
                                bit_d = 4'h1;
                            end else if (st_q == i2cpr_pkg::ST_OACK && two_l2
                                         && ob_q == 2'h1) begin
                                st_d = i2cpr_pkg::ST_OFFS;               // R8
                            end else if (st_q == i2cpr_pkg::ST_AACK) begin
                                st_d = i2cpr_pkg::ST_OFFS;
                            end else begin
                                st_d = i2cpr_pkg::ST_WDAT;
                            end
                        end
                    end
                end
                i2cpr_pkg::ST_RDAT: begin
                    if (fev) begin
                        if (bit_q == i2cpr_pkg::BYTE_DONE) begin
                            drv_d = 1'b0;
                            ph_d  = 1'b0;
                            st_d  = i2cpr_pkg::ST_RACK;
                        end else begin
                            drv_d = ~sh_q[7];
                            sh_d  = {sh_q[6:0], 1'b0};
                            bit_d = bit_q + 4'h1;
                        end
                    end
                end
                i2cpr_pkg::ST_RACK: begin
                    if (rise) begin
                        if (!sda_s2) begin
                            issue = 1'b1;  // prefetch only once the host acks
                            ph_d  = 1'b1;
                        end else begin
                            st_d = i2cpr_pkg::ST_IDLE;
                        end
                    end else if (fev && ph_q) begin
                        st_d  = i2cpr_pkg::ST_RDAT;
                        ph_d  = 1'b0;
                        drv_d = ~rdat_l[7];
                        sh_d  = {rdat_l[6:0], 1'b0};
                        bit_d = 4'h1;
                    end
                end
                default: drv_d = 1'b0;
            endcase
        end
        // hand one byte access to the core clock and advance the pointer
        if (issue) begin
            req_tog_d  = ~req_tog_q;
            req_wr_d   = iss_wr;
            req_addr_d = ptr_q;
            req_dat_d  = byte_in;
            ptr_d      = ptr_q + 16'h0001;                               // R13
            wait_d     = 1'b1;
        end
    end

    // link clock registers
    always_ff @(posedge link_clk_in) begin
        if (rl2) begin
            st_q <= i2cpr_pkg::ST_IDLE;  bit_q <= 4'h0;  sh_q <= 8'h00;
            ob_q <= 2'h0;  ptr_q <= 16'h0000;  rw_q <= 1'b0;  drv_q <= 1'b0;
            str_q <= 1'b0;  wait_q <= 1'b0;  ph_q <= 1'b0;  req_tog_q <= 1'b0;
            req_wr_q <= 1'b0;  req_addr_q <= 16'h0000;  req_dat_q <= 8'h00;
        end else if (cl2) begin
            st_q <= st_d;  bit_q <= bit_d;  sh_q <= sh_d;
            ob_q <= ob_d;  ptr_q <= ptr_d;  rw_q <= rw_d;  drv_q <= drv_d;
            str_q <= str_d;  wait_q <= wait_d;  ph_q <= ph_d;  req_tog_q <= req_tog_d;
            req_wr_q <= req_wr_d;  req_addr_q <= req_addr_d;  req_dat_q <= req_dat_d;
        end
    end

    // open-drain pins only ever pull low
    assign scl_out      = 1'b0;
    assign scl_oe_n_out = ~str_q;
    assign sda_out      = 1'b0;
    assign sda_oe_n_out = ~drv_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_user_half;
        @(posedge sys_clk_in) disable iff (rst_in || !ce_in)
        (cwr_q || crd_q) |-> caddr_q[i2cpr_pkg::USER_BIT];
    endproperty
    a_user_half: assert property (p_user_half) else $error("core access below 0x8000"); // R2

    property p_full_2b;
        @(posedge sys_clk_in) disable iff (rst_in || !ce_in)
        (cwr_q || crd_q) && two_byte_offset_mode_in |-> caddr_q == req_addr_q;
    endproperty
    a_full_2b: assert property (p_full_2b) else $error("two-byte address mismatch"); // R12

    property p_page_1b;
        @(posedge sys_clk_in) disable iff (rst_in || !ce_in)
        (cwr_q || crd_q) && !two_byte_offset_mode_in
            |-> caddr_q == {pg_q[15:8], req_addr_q[7:0]};
    endproperty
    a_page_1b: assert property (p_page_1b) else $error("one-byte paged address wrong"); // R10

    property p_page_wr;
        @(posedge sys_clk_in) disable iff (rst_in || !ce_in)
        req_ev && req_wr_q && pg_hit
            |=> pg_q[{$past(req_addr_q[1:0]), 3'h0} +: 8] == $past(req_dat_q);
    endproperty
    a_page_wr: assert property (p_page_wr) else $error("page byte not written"); // R11

    property p_def_addr;
        @(posedge sys_clk_in) disable iff (rst_in || !ce_in)
        !base_addr_valid_in && !strap_bit2_en_in
            |=> dev_q[6:2] == i2cpr_pkg::DEF_DEV_ADDR[6:2];
    endproperty
    a_def_addr: assert property (p_def_addr) else $error("default address wrong"); // R4

    property p_strap;
        @(posedge sys_clk_in) disable iff (rst_in || !ce_in)
        !$past(rst_in) && $stable({st1_s2, st0_s2}) ##1 $stable({st1_s2, st0_s2})
            |-> dev_q[1:0] == {st1_s2, st0_s2};
    endproperty
    a_strap: assert property (p_strap) else $error("strap bits not applied"); // R5

    property p_ptr_step;
        @(posedge link_clk_in) disable iff (rl2 || !cl2)
        $changed(req_tog_q) |-> ptr_q == req_addr_q + 16'h0001;
    endproperty
    a_ptr_step: assert property (p_ptr_step) else $error("pointer not advanced"); // R13

    property p_own_addr;
        @(posedge link_clk_in) disable iff (rl2 || !cl2)
        st_q == i2cpr_pkg::ST_AACK && $past(st_q) == i2cpr_pkg::ST_ADDR
            |-> sh_q[7:1] == $past(dev_l2);
    endproperty
    a_own_addr: assert property (p_own_addr) else $error("foreign address taken"); // R20

    property p_ready;
        @(posedge link_clk_in) disable iff (rl2 || !cl2)
        st_q == i2cpr_pkg::ST_AACK && $past(st_q) == i2cpr_pkg::ST_ADDR |-> $past(rdy_l2);
    endproperty
    a_ready: assert property (p_ready) else $error("answered before reset done"); // R17

    property p_stretch;
        @(posedge link_clk_in) disable iff (rl2 || !cl2)
        str_q |-> $past(wait_q) && !scl_s2;
    endproperty
    a_stretch: assert property (p_stretch) else $error("stretch without access"); // R16
endmodule // i2cpr_slave_port

// ===== bench/i2cpr_host_model.sv
// bus master model driving the two-wire pins of the slave port
`timescale 1ns/1ps
module i2cpr_host_model (
    input  wire logic scl_in,  // resolved clock wire
    input  wire logic sda_in,  // resolved data wire
    output logic      scl_out, // 0 pulls clock low
    output logic      sda_out, // 0 pulls data low
    output logic      stall_out // 1 once a stretch outlasted its bound
);
    localparam int Q = 150; // third of a bit; short high phase makes the device stretch
    initial begin
        scl_out   = 1'b1;
        sda_out   = 1'b1;
        stall_out = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // one bit: data set while clock low, sampled once the wire is high
    task automatic bit_io(input logic b, output logic r);
        int n;
        n = 0;
        scl_out = 1'b0;
        #Q sda_out = b;
        #Q scl_out = 1'b1;
        while (!scl_in && n < 500) begin // stretch wait is bounded
            #10 n++;
        end
        if (n >= 500) stall_out = 1'b1; // the bench counts this as a mismatch
        #Q r = sda_in;
    endtask
    // start or repeated start: data falls while clock high
    task automatic start();
        scl_out = 1'b0;
        #Q sda_out = 1'b1;
        #Q scl_out = 1'b1;
        #Q sda_out = 1'b0;
        #Q;
    endtask
    task automatic stop();
        scl_out = 1'b0;
        #Q sda_out = 1'b0;
        #Q scl_out = 1'b1;
        #Q sda_out = 1'b1;
        #Q;
    endtask
    // byte out msb first, data released for the acknowledge
    task automatic wb(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    // byte in; the last one is refused so the read ends
    task automatic rb(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(last, r);
    endtask
endmodule // i2cpr_host_model

// ===== bench/i2c_slave_paged_register_port_tb.sv
// self-checking bench for the paged register slave port
`timescale 1ns/1ps
module i2c_slave_paged_register_port_tb;
    typedef struct packed {
        logic v; logic [6:0] b; logic en; logic g; logic a1; logic a0; logic [6:0] e;
    } i2cpr_row_t;
    logic        sys_clk_in = 1'b0, link_clk_in = 1'b0, rst_in = 1'b1;
    logic        a0 = 1'b0, a1 = 1'b0, g2 = 1'b0, g2en = 1'b0, bval = 1'b0;
    logic        two = 1'b0, rdone = 1'b0;
    logic [6:0]  base = 7'h00, dev;
    logic [7:0]  crdata = 8'h00, cwd, wd, wd0;
    logic [15:0] caddr, wa, wa0, ra;
    logic        cwr, crd, mscl, msda, scl_oe_n, sda_oe_n, scl_o, sda_o, stall;
    int          bad_count = 0, samples_checked = 0, rd_n = 0;
    wire         scl = mscl & (scl_oe_n | scl_o); // pull-up unless someone pulls
    wire         sda = msda & (sda_oe_n | sda_o);
    i2cpr_row_t  rows [4] = '{'{0, 7'h00, 0, 0, 0, 0, 7'h58}, '{1, 7'h20, 0, 1, 1, 1, 7'h23},
                              '{0, 7'h00, 1, 1, 0, 1, 7'h5D}, '{1, 7'h7F, 1, 0, 0, 0, 7'h78}};
    initial forever #2.5 sys_clk_in = ~sys_clk_in;
    initial begin
        #7; // link phase unrelated to the core clock
        forever #24 link_clk_in = ~link_clk_in;
    end
    i2cpr_slave_port u_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(1'b1),
        .link_clk_in(link_clk_in), .scl_in(scl), .scl_out(scl_o), .scl_oe_n_out(scl_oe_n),
        .sda_in(sda), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n), .addr_strap_bit0_in(a0),
        .addr_strap_bit1_in(a1), .addr_strap_bit2_in(g2), .strap_bit2_en_in(g2en),
        .base_addr_in(base), .base_addr_valid_in(bval), .two_byte_offset_mode_in(two),
        .reset_done_in(rdone), .core_addr_out(caddr), .core_wdata_out(cwd),
        .core_wr_out(cwr), .core_rd_out(crd), .core_rdata_in(crdata), .dev_addr_out(dev));
    i2cpr_host_model u_h (.scl_in(scl), .sda_in(sda), .scl_out(mscl), .sda_out(msda),
        .stall_out(stall));
    ////////////////////////////////////////////////////////////////////////
    // core side: keep the last two writes and the last read address
    always @(posedge sys_clk_in) begin
        if (cwr) begin
            {wa0, wa} <= {wa, caddr};
            {wd0, wd} <= {wd, cwd};
        end
        if (crd) begin
            ra <= caddr;
            rd_n <= rd_n + 1;
        end
    end
    // read data follows the address one cycle late, valid when the port samples it
    always @(posedge sys_clk_in) crdata <= caddr[7:0] ^ 8'h3C;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // long reset: the link side needs three of its own edges
    task automatic rst_do();
        @(posedge sys_clk_in);
        rst_in <= 1'b1;
        repeat (40) @(posedge sys_clk_in);
        chk(16'(dev), 16'h0058);
        rst_in <= 1'b0;
        repeat (200) @(posedge sys_clk_in);
    endtask
    task automatic probe(input logic [7:0] adr, input logic exp);
        logic a;
        u_h.start();
        u_h.wb(adr, a);
        chk(16'(a), 16'(exp));
        u_h.stop();
    endtask
    task automatic wr(input logic [7:0] b[$], input logic st);
        logic a;
        u_h.start();
        foreach (b[i]) begin
            u_h.wb(b[i], a);
            chk(16'(a), 16'h0001);
        end
        if (st) u_h.stop();
    endtask
    // repeated start with read flag, then read and compare each byte
    task automatic rdb(input logic [7:0] e[$]);
        logic a;
        logic [7:0] r;
        u_h.start();
        u_h.wb(8'hB7, a);
        chk(16'(a), 16'h0001);
        foreach (e[i]) begin
            u_h.rb(i == e.size() - 1, r);
            chk(16'(r), 16'(e[i]));
        end
        u_h.stop();
    endtask
    initial begin
        #480000; // about 96k core cycles
        bad_count++;
        conclude();
    end
    ////////////////////////////////////////////////////////////////////////
    // straps stay put while the bus runs; only changed one core cycle before a reset
    initial begin
        int n;
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk_in);
            {bval, base, g2en, g2, a1, a0} <= rows[i][18:7];
            rst_do();
            chk(16'(dev), 16'(rows[i].e));
        end
        $display("address rows done");
        {bval, g2en, a1, a0} <= 4'b0011;
        rst_do();
        probe(8'hB6, 1'b0);
        @(posedge sys_clk_in);
        rdone <= 1'b1;
        probe(8'hB4, 1'b0);
        probe(8'hB6, 1'b1);
        $display("address answer done");
        wr('{8'hB6, 8'hFC, 8'h00, 8'hCB, 8'h10, 8'h20}, 1'b1);
        wr('{8'hB6, 8'hE4, 8'h50, 8'h51}, 1'b1);
        chk(wa0, 16'hCBE4);
        chk({wd0, wd}, 16'h5051);
        chk(wa, 16'hCBE5);
        wr('{8'hB6, 8'h24}, 1'b0);
        rdb('{8'h18, 8'h19});
        chk(ra, 16'hCB25);
        wr('{8'hB6, 8'hFC}, 1'b0);
        rdb('{8'h00, 8'hCB, 8'h10, 8'h20});
        $display("one-byte mode done");
        @(posedge sys_clk_in);
        two <= 1'b1;
        rst_do();
        wr('{8'hB6, 8'hFF, 8'hFC, 8'h00, 8'hCB, 8'h10, 8'h20}, 1'b1);
        wr('{8'hB6, 8'hCB, 8'hE4, 8'h50}, 1'b1);
        chk(wa, 16'hCBE4);
        wr('{8'hB6, 8'hC0, 8'h24}, 1'b0);
        rdb('{8'h18});
        chk(ra, 16'hC024);
        n = rd_n;
        wr('{8'hB6, 8'h00, 8'h10}, 1'b0);
        rdb('{8'h00});
        chk(16'(rd_n - n), 16'h0000);
        $display("two-byte mode done");
        chk(16'(stall), 16'h0000);
        conclude();
    end
endmodule // i2c_slave_paged_register_port_tb
